// ==== core/cesm_consts.svh ====
`ifndef CESM_CONSTS_SVH
`define CESM_CONSTS_SVH

// Register offsets
`define CESM_TX_ERR_COUNT_OFS 8'h1C
`define CESM_RX_ERR_COUNT_OFS 8'h1D
`define CESM_ERROR_FLAG_REG_OFS 8'h2D

// Reset values
`define CESM_COUNT_RST 8'h00
`define CESM_FLAGS_RST 8'h00

// Error flag register bit positions
`define CESM_RX_BUF1_OVERFLOW_BIT 7
`define CESM_RX_BUF0_OVERFLOW_BIT 6
`define CESM_BUS_OFF_FLAG_BIT 5
`define CESM_TX_PASSIVE_FLAG_BIT 4
`define CESM_RX_PASSIVE_FLAG_BIT 3
`define CESM_TX_WARNING_FLAG_BIT 2
`define CESM_RX_WARNING_FLAG_BIT 1
`define CESM_COMBINED_WARNING_FLAG_BIT 0

// Limits
`define CESM_WARN_LIMIT 8'h60
`define CESM_PASSIVE_LIMIT 8'h80
`define CESM_COUNT_MAX 9'h0FF
`define CESM_INC_SMALL 9'h001
`define CESM_INC_LARGE 9'h008

// Bus-off recovery: 128 runs of 11 recessive bits
`define CESM_RECOV_RUN_BITS 4'hB
`define CESM_RECOV_RUNS 8'h80

`endif

// ==== core/cesm_pkg.sv ====
package cesm_pkg;

	typedef enum logic {
		CESM_ERR_ACTIVE,
		CESM_BUS_OFF
	} cesm_mode_e;

	typedef struct packed {
		logic [7:0] tx_err_count;
		logic [7:0] rx_err_count;
		cesm_mode_e mode;
		logic rx_buf0_overflow;
		logic rx_buf1_overflow;
		logic [3:0] run_bits;
		logic [7:0] run_count;
		logic [7:0] reg_rdata;
		logic reg_rvalid;
	} cesm_state_s;

	typedef logic [7:0] cesm_byte_t;

endpackage : cesm_pkg

// ==== core/cesm_flag_if.sv ====
`timescale 1ns/100ps
interface cesm_flag_if;
	logic [7:0] tx_err_count;
	logic [7:0] rx_err_count;
	logic tx_warning_flag;
	logic rx_warning_flag;
	logic tx_passive_flag;
	logic rx_passive_flag;

	modport mon (
		output tx_err_count,
		output rx_err_count,
		input tx_warning_flag,
		input rx_warning_flag,
		input tx_passive_flag,
		input rx_passive_flag
	);

	modport thr (
		input tx_err_count,
		input rx_err_count,
		output tx_warning_flag,
		output rx_warning_flag,
		output tx_passive_flag,
		output rx_passive_flag
	);
endinterface : cesm_flag_if

// ==== core/cesm_thresholds.sv ====
`timescale 1ns/100ps
`include "cesm_consts.svh"
module cesm_thresholds (
	// Counts in, flags out
	cesm_flag_if.thr flags
);
	import cesm_pkg::*;

	// Pure compares, so flags follow a counter change in the same cycle
	assign flags.tx_passive_flag = (flags.tx_err_count >= `CESM_PASSIVE_LIMIT);
	assign flags.rx_passive_flag = (flags.rx_err_count >= `CESM_PASSIVE_LIMIT);
	assign flags.tx_warning_flag = (flags.tx_err_count >= `CESM_WARN_LIMIT);
	assign flags.rx_warning_flag = (flags.rx_err_count >= `CESM_WARN_LIMIT);

endmodule : cesm_thresholds

// ==== core/cesm_monitor.sv ====
// Function
// - Transmit error count readable as 8-bit read-only register, resets to zero.
// - Receive error count readable as 8-bit read-only register, resets to zero.
// - Buffer-0 overflow sets on accept while full; held until host clears.
// - Read-only bus-off flag: set entering bus-off, cleared after recovery.
// - Transmit error-passive flag high while transmit count at least 128.
// - Receive error-passive flag high while receive count at least 128.
// - Transmit warning flag high while transmit count at least 96.
// - Receive warning flag high while receive count at least 96.
// - Combined warning high when either count at least 96, else low.
// - Transmit count passing 255 enters bus-off; no transmit or receive there.
// - Bus-off ends alone after 128 runs of 11 recessive bits.
`timescale 1ns/100ps
`include "cesm_consts.svh"
module cesm_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register access
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire cesm_pkg::cesm_byte_t reg_addr,
	input wire cesm_pkg::cesm_byte_t reg_wdata,
	input wire cesm_pkg::cesm_byte_t reg_wmask,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Counter update events from the protocol engine
	input wire logic tx_err_inc_small,
	input wire logic tx_err_inc_large,
	input wire logic tx_err_dec,
	input wire logic rx_err_inc_small,
	input wire logic rx_err_inc_large,
	input wire logic rx_err_dec,
	// Receive buffer events
	input wire logic rx_buf0_accept,
	input wire logic rx_buf1_accept,
	input wire logic rx_buf0_full_flag,
	input wire logic rx_buf1_full_flag,
	// Bus bit sampling
	input wire logic bus_bit_valid,
	input wire logic bus_bit_recessive,
	// Status outputs
	output logic bus_off,
	output logic error_passive,
	output logic [7:0] error_flag_reg
);
	import cesm_pkg::*;

	cesm_state_s st;
	cesm_state_s next_st;
	cesm_flag_if flags ();
	logic [8:0] tx_sum;
	logic [8:0] rx_sum;
	logic combined_warning_flag;
	logic [7:0] flag_word;
	logic [7:0] ovr_clear;

	assign flags.tx_err_count = st.tx_err_count;
	assign flags.rx_err_count = st.rx_err_count;

	cesm_thresholds u_thresholds (
		.flags(flags)
	);

	// Either counter at the warning limit raises the combined flag
	assign combined_warning_flag = flags.tx_warning_flag | flags.rx_warning_flag;

	// Flag register image
	always_comb begin
		flag_word = `CESM_FLAGS_RST;
		flag_word[`CESM_RX_BUF1_OVERFLOW_BIT] = st.rx_buf1_overflow;
		flag_word[`CESM_RX_BUF0_OVERFLOW_BIT] = st.rx_buf0_overflow;
		flag_word[`CESM_BUS_OFF_FLAG_BIT] = (st.mode == CESM_BUS_OFF);
		flag_word[`CESM_TX_PASSIVE_FLAG_BIT] = flags.tx_passive_flag;
		flag_word[`CESM_RX_PASSIVE_FLAG_BIT] = flags.rx_passive_flag;
		flag_word[`CESM_TX_WARNING_FLAG_BIT] = flags.tx_warning_flag;
		flag_word[`CESM_RX_WARNING_FLAG_BIT] = flags.rx_warning_flag;
		flag_word[`CESM_COMBINED_WARNING_FLAG_BIT] = combined_warning_flag;
	end

	// Bits a write clears: masked and written as zero
	assign ovr_clear = (reg_wr && (reg_addr == `CESM_ERROR_FLAG_REG_OFS)) ?
		(reg_wmask & ~reg_wdata) : 8'h00;

	// Next state
	always_comb begin
		next_st = st;
		tx_sum = {1'b0, st.tx_err_count};
		rx_sum = {1'b0, st.rx_err_count};
		next_st.reg_rvalid = 1'b0;
		case (st.mode)
			CESM_ERR_ACTIVE: begin
				// Transmit counter
				if (tx_err_inc_large) begin
					tx_sum = {1'b0, st.tx_err_count} + `CESM_INC_LARGE;
				end else if (tx_err_inc_small) begin
					tx_sum = {1'b0, st.tx_err_count} + `CESM_INC_SMALL;
				end else if (tx_err_dec && (st.tx_err_count != 8'h00)) begin
					tx_sum = {1'b0, st.tx_err_count} - `CESM_INC_SMALL;
				end
				// Receive counter, saturating
				if (rx_err_inc_large) begin
					rx_sum = {1'b0, st.rx_err_count} + `CESM_INC_LARGE;
				end else if (rx_err_inc_small) begin
					rx_sum = {1'b0, st.rx_err_count} + `CESM_INC_SMALL;
				end else if (rx_err_dec && (st.rx_err_count != 8'h00)) begin
					rx_sum = {1'b0, st.rx_err_count} - `CESM_INC_SMALL;
				end
				if (rx_sum > `CESM_COUNT_MAX) begin
					rx_sum = `CESM_COUNT_MAX;
				end
				next_st.rx_err_count = rx_sum[7:0];
				if (tx_sum > `CESM_COUNT_MAX) begin
					// Passing 255 takes the node off the bus
					next_st.mode = CESM_BUS_OFF;
					next_st.tx_err_count = 8'(`CESM_COUNT_MAX);
					next_st.run_bits = 4'h0;
					next_st.run_count = 8'h00;
				end else begin
					next_st.tx_err_count = tx_sum[7:0];
				end
			end
			CESM_BUS_OFF: begin
				// Counter events ignored; count recessive runs
				if (bus_bit_valid) begin
					if (!bus_bit_recessive) begin
						next_st.run_bits = 4'h0;
					end else if (st.run_bits == (`CESM_RECOV_RUN_BITS - 4'h1)) begin
						next_st.run_bits = 4'h0;
						next_st.run_count = st.run_count + 8'h01;
						if (st.run_count == (`CESM_RECOV_RUNS - 8'h01)) begin
							// Recovery complete: back to error-active, counters cleared
							next_st.mode = CESM_ERR_ACTIVE;
							next_st.tx_err_count = `CESM_COUNT_RST;
							next_st.rx_err_count = `CESM_COUNT_RST;
							next_st.run_count = 8'h00;
						end
					end else begin
						next_st.run_bits = st.run_bits + 4'h1;
					end
				end
			end
			default: begin
				next_st.mode = CESM_ERR_ACTIVE;
			end
		endcase
		// Overflow flags: set wins over a host clear in the same cycle
		next_st.rx_buf0_overflow = (rx_buf0_accept && rx_buf0_full_flag) ||
			(st.rx_buf0_overflow && !ovr_clear[`CESM_RX_BUF0_OVERFLOW_BIT]);
		next_st.rx_buf1_overflow = (rx_buf1_accept && rx_buf1_full_flag) ||
			(st.rx_buf1_overflow && !ovr_clear[`CESM_RX_BUF1_OVERFLOW_BIT]);
		// Register reads; counts and derived bits are read-only
		if (reg_rd) begin
			next_st.reg_rvalid = 1'b1;
			if (reg_addr == `CESM_TX_ERR_COUNT_OFS) begin
				next_st.reg_rdata = st.tx_err_count;
			end else if (reg_addr == `CESM_RX_ERR_COUNT_OFS) begin
				next_st.reg_rdata = st.rx_err_count;
			end else if (reg_addr == `CESM_ERROR_FLAG_REG_OFS) begin
				next_st.reg_rdata = flag_word;
			end else begin
				next_st.reg_rdata = 8'h00;
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{
				tx_err_count: `CESM_COUNT_RST,
				rx_err_count: `CESM_COUNT_RST,
				mode: CESM_ERR_ACTIVE,
				rx_buf0_overflow: 1'b0,
				rx_buf1_overflow: 1'b0,
				run_bits: 4'h0,
				run_count: 8'h00,
				reg_rdata: 8'h00,
				reg_rvalid: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign reg_rdata = st.reg_rdata;
	assign reg_rvalid = st.reg_rvalid;
	assign bus_off = (st.mode == CESM_BUS_OFF);
	assign error_passive = flags.tx_passive_flag | flags.rx_passive_flag;
	assign error_flag_reg = flag_word;

endmodule : cesm_monitor

// ==== sim/cesm_monitor_chk.sv ====
`timescale 1ns/100ps
module cesm_monitor_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire cesm_pkg::cesm_byte_t reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic rx_buf0_accept,
	input wire logic rx_buf0_full_flag,
	input wire logic rx_buf1_accept,
	input wire logic rx_buf1_full_flag,
	input wire logic bus_off,
	input wire logic error_passive,
	input wire logic [7:0] error_flag_reg
);
	import cesm_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
		else $error("rvalid timing");
	flag_read_a: assert property (reg_rd && reg_addr == 8'h2D |=>
		reg_rdata == $past(error_flag_reg)) else $error("stale flag read");
	passive_sum_a: assert property (error_passive ==
		(error_flag_reg[4] | error_flag_reg[3])) else $error("passive output");
	tx_order_a: assert property (error_flag_reg[4] |-> error_flag_reg[2])
		else $error("tx passive without warning");
	rx_order_a: assert property (error_flag_reg[3] |-> error_flag_reg[1])
		else $error("rx passive without warning");
	combined_warn_a: assert property (error_flag_reg[0] ==
		(error_flag_reg[2] | error_flag_reg[1])) else $error("combined warning");
	bus_off_flag_a: assert property (bus_off == error_flag_reg[5])
		else $error("bus-off flag");
	busoff_entry_a: assert property ($rose(bus_off) |-> error_flag_reg[4])
		else $error("bus-off below passive");
	ovf0_set_a: assert property (rx_buf0_accept && rx_buf0_full_flag |=>
		error_flag_reg[6]) else $error("overflow not set");
	ovf0_cause_a: assert property ($rose(error_flag_reg[6]) |->
		$past(rx_buf0_accept) && $past(rx_buf0_full_flag)) else $error("overflow cause");
	ovf0_hold_a: assert property (error_flag_reg[6] && !reg_wr |=>
		error_flag_reg[6]) else $error("overflow 0 lost");
	ovf1_set_a: assert property (rx_buf1_accept && rx_buf1_full_flag |=>
		error_flag_reg[7]) else $error("overflow 1 not set");
	ovf1_hold_a: assert property (error_flag_reg[7] && !reg_wr |=>
		error_flag_reg[7]) else $error("overflow 1 lost");
endmodule : cesm_monitor_chk
bind cesm_monitor cesm_monitor_chk chk_u (.clk(clk), .rst(rst), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.rx_buf0_accept(rx_buf0_accept), .rx_buf0_full_flag(rx_buf0_full_flag),
	.rx_buf1_accept(rx_buf1_accept), .rx_buf1_full_flag(rx_buf1_full_flag),
	.bus_off(bus_off), .error_passive(error_passive), .error_flag_reg(error_flag_reg));

// ==== sim/cesm_host.sv ====
`timescale 1ns/100ps
module cesm_host (
	// Bus
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_rd,
	output logic reg_wr,
	output cesm_pkg::cesm_byte_t reg_addr,
	output cesm_pkg::cesm_byte_t reg_wdata,
	output cesm_pkg::cesm_byte_t reg_wmask
);
	import cesm_pkg::*;
	initial begin
		{reg_rd, reg_wr, reg_addr, reg_wdata, reg_wmask} = '0;
	end
	// Read, data one cycle after the request edge
	task automatic rd(input cesm_byte_t a, output cesm_byte_t d);
		@(posedge clk) #1;
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk) #1;
		d = reg_rdata;
		reg_rd = 1'b0;
	endtask : rd
	task automatic wr(input cesm_byte_t a, m, w);
		@(posedge clk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wmask = m;
		reg_wdata = w;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask : wr
endmodule : cesm_host

// ==== sim/cesm_monitor_bench.sv ====
`timescale 1ns/100ps
module cesm_monitor_bench;
	import cesm_pkg::*;
	typedef struct {int td; int rd; cesm_byte_t tx; cesm_byte_t rx; cesm_byte_t fl;} cesm_row_s;
	logic clk, rst, reg_rd, reg_wr, reg_rvalid, bus_off, error_passive;
	cesm_byte_t reg_addr, reg_wdata, reg_wmask, d;
	logic [7:0] reg_rdata, error_flag_reg;
	logic [5:0] ev;
	logic [3:0] rxb;
	logic [1:0] bb;
	int err_total, n_compared, cyc;
	cesm_row_s rows [8] = '{'{95, 0, 8'h5F, 8'h00, 8'h00}, '{1, 0, 8'h60, 8'h00, 8'h05},
		'{0, 96, 8'h60, 8'h60, 8'h07}, '{32, 0, 8'h80, 8'h60, 8'h17},
		'{0, 32, 8'h80, 8'h80, 8'h1F}, '{-1, 0, 8'h7F, 8'h80, 8'h0F},
		'{0, -33, 8'h7F, 8'h5F, 8'h05}, '{-32, 0, 8'h5F, 8'h5F, 8'h00}};
	cesm_monitor dut_u (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_err_inc_small(ev[5]),
		.tx_err_inc_large(ev[4]), .tx_err_dec(ev[3]), .rx_err_inc_small(ev[2]),
		.rx_err_inc_large(ev[1]), .rx_err_dec(ev[0]), .rx_buf0_accept(rxb[3]),
		.rx_buf1_accept(rxb[2]), .rx_buf0_full_flag(rxb[1]), .rx_buf1_full_flag(rxb[0]),
		.bus_bit_valid(bb[1]), .bus_bit_recessive(bb[0]), .bus_off(bus_off),
		.error_passive(error_passive), .error_flag_reg(error_flag_reg));
	cesm_host host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// Hold the event inputs set in mask m for n cycles
	task automatic ev_run(input logic [5:0] m, input int n);
		@(posedge clk) #1;
		ev = m;
		repeat (n) @(posedge clk);
		#1 ev = '0;
	endtask : ev_run
	task automatic regs(input cesm_byte_t tx, rx, fl);
		host_u.rd(8'h1C, d);
		chk(d, tx);
		host_u.rd(8'h1D, d);
		chk(d, rx);
		host_u.rd(8'h2D, d);
		chk(d, fl);
	endtask : regs
	initial begin
		rst = 1'b1;
		{ev, rxb, bb} = '0;
		{err_total, n_compared, cyc} = '0;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		regs(8'h00, 8'h00, 8'h00);
		host_u.rd(8'h2E, d);
		chk(d, 8'h00);
		host_u.wr(8'h1C, 8'hFF, 8'hAA);
		host_u.wr(8'h1D, 8'hFF, 8'hAA);
		host_u.wr(8'h2D, 8'hFF, 8'hFF);
		// Decrement at zero leaves both counts at zero
		ev_run(6'h09, 1);
		regs(8'h00, 8'h00, 8'h00);
		foreach (rows[i]) begin
			if (rows[i].td > 0) ev_run(6'h20, rows[i].td);
			if (rows[i].td < 0) ev_run(6'h08, -rows[i].td);
			if (rows[i].rd > 0) ev_run(6'h04, rows[i].rd);
			if (rows[i].rd < 0) ev_run(6'h01, -rows[i].rd);
			chk(error_flag_reg, rows[i].fl);
			chk({7'h00, error_passive}, {7'h00, rows[i].fl[4] | rows[i].fl[3]});
			regs(rows[i].tx, rows[i].rx, rows[i].fl);
		end
		@(posedge clk) #1 rxb = 4'hC;
		@(posedge clk) #1 rxb = 4'hF;
		chk(error_flag_reg, 8'h00);
		@(posedge clk) #1 rxb = 4'h3;
		chk(error_flag_reg, 8'hC0);
		host_u.wr(8'h2D, 8'hC0, 8'hFF);
		chk(error_flag_reg, 8'hC0);
		host_u.wr(8'h2D, 8'h40, 8'h00);
		chk(error_flag_reg, 8'h80);
		host_u.wr(8'h2D, 8'h80, 8'h00);
		chk(error_flag_reg, 8'h00);
		// Overflow event and host clear in one cycle: the event wins
		rxb = 4'hF;
		host_u.wr(8'h2D, 8'hC0, 8'h00);
		rxb = 4'h3;
		chk(error_flag_reg, 8'hC0);
		host_u.wr(8'h2D, 8'hC0, 8'h00);
		chk(error_flag_reg, 8'h00);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		ev_run(6'h10, 31);
		chk(error_flag_reg, 8'h15);
		ev_run(6'h10, 1);
		chk({7'h00, bus_off}, 8'h01);
		ev_run(6'h04, 4);
		regs(8'hFF, 8'h00, 8'h35);
		// Nine runs, then a dominant bit cuts the tenth; 1309 more bits finish
		@(posedge clk) #1 bb = 2'b11;
		repeat (100) @(posedge clk);
		#1 bb = 2'b10;
		@(posedge clk) #1 bb = 2'b11;
		repeat (1308) @(posedge clk);
		#1 chk({7'h00, bus_off}, 8'h01);
		@(posedge clk) #1 bb = 2'b00;
		@(posedge clk) #1 chk({7'h00, bus_off}, 8'h00);
		regs(8'h00, 8'h00, 8'h00);
		// Receive count saturates at 255 and never goes bus-off
		ev_run(6'h02, 32);
		regs(8'h00, 8'hFF, 8'h0B);
		chk({7'h00, bus_off}, 8'h00);
		complete_run();
	end
endmodule : cesm_monitor_bench
